// *** rtl/fail_safe_monitor.v ***
// Function
// - Detect failure only after startup timer expires
// - Monitor active only when config enable set
// - Monitoring covers every external oscillator mode
// - Sample clock is internal osc divided 64
// - Latch set on external clock falling edge
// - Latch cleared on sample clock rising edge
// - Fail on full sample period without edge
// - On failure switch internal, set fail flag
// - Flag and enable raise interrupt request
// - Stay internal until firmware switches back
// - Fallback frequency from frequency select field
// - Reset, sleep, select change clear fail-safe (code: select change clears it only when the restarted timer expires)
// - Select change restarts startup timer
// - Run internal while restarted timer counts
// - Clear fail-safe after switch to external
// - Still failing sets flag again
// - Startup timer runs after wake and reset
// - Clock input and RC modes skip timer
// - Monitor enable also enables two-speed start
// - Reset loads 500 kHz frequency select pattern
`timescale 1ns/1ps
`default_nettype none
`include "fail_safe_monitor_regs.vh"
module fail_safe_monitor #(
   parameter STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter SAMPLE_DIV = `SAMPLE_DIV
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire monitor_enable_cfg_i,
   input wire [2:0] osc_mode_i,
   input wire ext_clk_i,
   input wire low_freq_internal_osc_i,
   input wire wake_i,
   output reg use_internal_o,
   output reg [3:0] internal_freq_select_o,
   output reg [1:0] clock_select_field_o,
   output reg sleep_req_o,
   output reg irq_o
);
   localparam ST_STARTUP = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_FAILED = 2'h2;
   localparam ST_SLEEP = 2'h3;
   localparam HALF_DIV = SAMPLE_DIV / 2;

   reg [1:0] state;
   reg [31:0] ost_count;
   reg [7:0] div_count;
   reg low_q;
   reg ext_q;
   reg sample_clk;
   reg sample_rise;
   reg edge_latch;
   reg fail_safe;
   reg clock_fail_flag;
   reg clock_fail_irq_enable;
   reg fail_event;
   wire monitor_on;
   wire skip_timer;
   wire wr;
   wire csel_change;
   wire sleep_cmd;

   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   // Only an actual change of the select field restarts the timer
   assign csel_change = wr && wb_adr_i == `ADDR_OSC_CTRL && wb_sel_i[0] &&
      wb_dat_i[`CSEL_MSB:`CSEL_LSB] != clock_select_field_o;
   assign sleep_cmd = wr && wb_adr_i == `ADDR_OSC_CTRL && wb_sel_i[1] &&
      wb_dat_i[`SLEEP_BIT];
   assign skip_timer = osc_mode_i == `MODE_EC || osc_mode_i == `MODE_RC;
   // All modes monitored; only the timer skip is mode dependent
   assign monitor_on = monitor_enable_cfg_i && state == ST_RUN;

   // Sample clock: edges of the slow oscillator counted, toggled every 32
   always @(posedge clk_i) begin
      if (rst_i) begin
         low_q <= 1'b0;
         div_count <= 8'h00;
         sample_clk <= 1'b0;
         sample_rise <= 1'b0;
      end else begin
         low_q <= low_freq_internal_osc_i;
         sample_rise <= 1'b0;
         if (low_freq_internal_osc_i & ~low_q) begin
            if (div_count == HALF_DIV - 1) begin
               div_count <= 8'h00;
               sample_clk <= ~sample_clk;
               sample_rise <= ~sample_clk;
            end else begin
               div_count <= div_count + 8'h01;
            end
         end
      end
   end

   // Fail detector latch; a falling edge in the clearing cycle wins
   always @(posedge clk_i) begin
      if (rst_i) begin
         ext_q <= 1'b1;
         edge_latch <= 1'b1;
         fail_event <= 1'b0;
      end else begin
         ext_q <= ext_clk_i;
         fail_event <= 1'b0;
         if (ext_q & ~ext_clk_i) begin
            edge_latch <= 1'b1;
         end else if (sample_rise) begin
            edge_latch <= 1'b0;
            // Latch still clear at rise means a whole sample period passed
            fail_event <= ~edge_latch & monitor_on;
         end
      end
   end

   // Startup timer and fail-safe state
   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_STARTUP;
         ost_count <= 32'h0;
         fail_safe <= 1'b0;
      end else begin
         case (state)
            ST_STARTUP: begin
               if (skip_timer || ost_count >= STARTUP_CYCLES - 1) begin
                  state <= ST_RUN;
                  fail_safe <= 1'b0;
                  ost_count <= 32'h0;
               end else begin
                  ost_count <= ost_count + 32'h1;
               end
            end
            ST_RUN: begin
               if (fail_event) begin
                  state <= ST_FAILED;
                  fail_safe <= 1'b1;
               end
            end
            ST_FAILED: begin
               state <= ST_FAILED;
            end
            ST_SLEEP: begin
               if (wake_i) begin
                  state <= ST_STARTUP;
                  ost_count <= 32'h0;
               end
            end
            default: state <= ST_STARTUP;
         endcase
         if (sleep_cmd) begin
            state <= ST_SLEEP;
            fail_safe <= 1'b0;
         end else if (csel_change) begin
            state <= ST_STARTUP;
            ost_count <= 32'h0;
         end
      end
   end

   // Internal clock while timer runs (two-speed) or while failed
   always @(posedge clk_i) begin
      if (rst_i) begin
         use_internal_o <= 1'b1;
      end else begin
         use_internal_o <= (monitor_enable_cfg_i && state == ST_STARTUP) ||
            fail_safe || fail_event || clock_select_field_o[1];
      end
   end

   // Registers
   always @(posedge clk_i) begin
      if (rst_i) begin
         internal_freq_select_o <= `IFS_RESET;
         clock_select_field_o <= `CSEL_RESET;
         sleep_req_o <= 1'b0;
         clock_fail_flag <= 1'b0;
         clock_fail_irq_enable <= 1'b0;
         irq_o <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         sleep_req_o <= sleep_cmd;
         if (wr && wb_adr_i == `ADDR_OSC_CTRL && wb_sel_i[0]) begin
            internal_freq_select_o <= wb_dat_i[`IFS_MSB:`IFS_LSB];
            clock_select_field_o <= wb_dat_i[`CSEL_MSB:`CSEL_LSB];
         end
         if (wr && wb_adr_i == `ADDR_ENABLE_TWO && wb_sel_i[0]) begin
            clock_fail_irq_enable <= wb_dat_i[`FAIL_BIT];
         end
         // Set wins over a software clear in the same cycle
         if (fail_event) begin
            clock_fail_flag <= 1'b1;
         end else if (wr && wb_adr_i == `ADDR_FLAG_TWO && wb_sel_i[0] &&
               !wb_dat_i[`FAIL_BIT]) begin
            clock_fail_flag <= 1'b0;
         end
         irq_o <= clock_fail_flag & clock_fail_irq_enable;
         wb_dat_o <= 32'h0;
         if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
            case (wb_adr_i)
               `ADDR_OSC_CTRL: wb_dat_o <= {25'h0, internal_freq_select_o, 1'b0,
                  clock_select_field_o};
               `ADDR_OSC_STATE: wb_dat_o <= {28'h0, fail_safe, use_internal_o,
                  state};
               `ADDR_FLAG_TWO: wb_dat_o <= {24'h0, clock_fail_flag, 7'h0};
               `ADDR_ENABLE_TWO: wb_dat_o <= {24'h0, clock_fail_irq_enable, 7'h0};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** rtl/fail_safe_monitor_regs.vh ***
`ifndef FAIL_SAFE_MONITOR_REGS_VH
`define FAIL_SAFE_MONITOR_REGS_VH
// Register byte addresses
`define ADDR_OSC_CTRL 4'h0
`define ADDR_OSC_STATE 4'h4
`define ADDR_FLAG_TWO 4'h8
`define ADDR_ENABLE_TWO 4'hC
// oscillator_control_reg fields
`define IFS_LSB 3
`define IFS_MSB 6
`define CSEL_LSB 0
`define CSEL_MSB 1
`define SLEEP_BIT 8
// Flag and enable bit positions
`define FAIL_BIT 7
// Reset values
`define IFS_RESET 4'h7
`define CSEL_RESET 2'h0
// Oscillator modes
`define MODE_LP 3'h0
`define MODE_XT 3'h1
`define MODE_HS 3'h2
`define MODE_EC 3'h3
`define MODE_SOSC 3'h4
`define MODE_RC 3'h5
// Timing
`define SAMPLE_DIV 64
`define STARTUP_CYCLES 1024
`endif

// *** dv/ext_osc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model (
   input wire logic clk_i,
   input wire logic run_i,
   output wire logic osc_o
);
   logic [1:0] div = 2'h0;
   // A dead crystal freezes at its last level
   always @(posedge clk_i) if (run_i) div <= div + 2'h1;
   assign osc_o = div[1];
endmodule
`default_nettype wire

// *** dv/fail_safe_monitor_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fail_safe_monitor_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_ack_o,
   input wire logic use_internal_o,
   input wire logic [3:0] internal_freq_select_o,
   input wire logic [1:0] clock_select_field_o,
   input wire logic sleep_req_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [31:0] dat_q;
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire ctl = take && wb_we_i && wb_adr_i == 4'h0;
   always @(posedge clk_i) dat_q <= wb_dat_i;
   AST_ACK_NEXT: assert property (take |=> wb_ack_o) else $error("ack late");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   AST_RST_VAL: assert property ($past(rst_i) |-> use_internal_o && !irq_o
      && internal_freq_select_o == 4'h7 && clock_select_field_o == 2'h0) else $error("bad reset");
   AST_FREQ_WR: assert property (ctl && wb_sel_i[0] |=>
      internal_freq_select_o == dat_q[6:3]) else $error("freq field");
   AST_SEL_WR: assert property (ctl && wb_sel_i[0] |=>
      clock_select_field_o == dat_q[1:0]) else $error("select field");
   AST_SLEEP: assert property (ctl && wb_sel_i[1] && wb_dat_i[8] |=>
      sleep_req_o ##1 !sleep_req_o) else $error("sleep pulse");
   AST_IRQ_HOLD: assert property (!(take && wb_we_i) ##1 irq_o |=> irq_o)
      else $error("irq lost");
   AST_IRQ_OFF: assert property (take && wb_we_i && wb_adr_i == 4'hC && wb_sel_i[0]
      && !wb_dat_i[7] |=> ##1 !irq_o) else $error("irq not masked");
   cover property ($rose(irq_o));
   cover property ($rose(use_internal_o));
   cover property (sleep_req_o);
endmodule
bind fail_safe_monitor fail_safe_monitor_assertions chk (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .use_internal_o,
   .internal_freq_select_o, .clock_select_field_o, .sleep_req_o, .irq_o);
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic cfg = 1'b1, run = 1'b1, wake = 1'b0, wb_ack_o, ext, use_int, irq;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [2:0] lf = 3'h0, mode = 3'h1;
   // Address, write data, read-back data
   logic [27:0] rows [6] = '{28'h007F07B, 28'h0038038, 28'h2FFF000, 28'h8080000,
      28'hC000000, 28'hC0FF080};
   int fails = 0, cmp_count = 0;
   ext_osc_model osc (.clk_i, .run_i(run), .osc_o(ext));
   fail_safe_monitor #(.STARTUP_CYCLES(16), .SAMPLE_DIV(4)) dut (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
      .monitor_enable_cfg_i(cfg), .osc_mode_i(mode), .ext_clk_i(ext),
      .low_freq_internal_osc_i(lf[2]), .wake_i(wake), .use_internal_o(use_int),
      .internal_freq_select_o(), .clock_select_field_o(), .sleep_req_o(), .irq_o(irq));
   initial forever #20 clk_i = ~clk_i;
   always @(posedge clk_i) lf <= lf + 3'h1;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n == 20) chk(32'h0, 32'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Bounded so a dead detector cannot hang the run
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 600) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic do_rst;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (10000) @(posedge clk_i);
      fails++;
      give_verdict;
   end
   initial begin
      do_rst;
      bus(4'h4, 32'h0, 1'b0);
      chk(q, 32'h4);
      bus(4'h0, 32'h0, 1'b0);
      chk(q, 32'h38);
      foreach (rows[i]) begin
         bus(rows[i][27:24], {20'h0, rows[i][23:12]}, 1'b1);
         bus(rows[i][27:24], 32'h0, 1'b0);
         chk(q, {20'h0, rows[i][11:0]});
      end
      $display("register rows done");
      repeat (300) @(posedge clk_i);
      bus(4'h4, 32'h0, 1'b0);
      chk(q, 32'h1);
      run <= 1'b0;
      wait_irq;
      chk({31'h0, irq}, 32'h1);
      chk({31'h0, use_int}, 32'h1);
      bus(4'h4, 32'h0, 1'b0);
      chk(q, 32'hE);
      bus(4'h8, 32'h80, 1'b1);
      bus(4'h8, 32'h0, 1'b0);
      chk(q, 32'h80);
      bus(4'h8, 32'h0, 1'b1);
      bus(4'h8, 32'h0, 1'b0);
      chk(q, 32'h0);
      $display("failure test done");
      bus(4'h0, 32'h138, 1'b1);
      bus(4'h4, 32'h0, 1'b0);
      chk(q & 32'hB, 32'h3);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      wait_irq;
      chk({31'h0, irq}, 32'h1);
      bus(4'h8, 32'h0, 1'b1);
      bus(4'h0, 32'h39, 1'b1);
      bus(4'h4, 32'h0, 1'b0);
      // Timer restarted; fail-safe stays until the timer runs out
      chk(q & 32'hB, 32'h8);
      $display("sleep and reselect done");
      cfg <= 1'b0;
      do_rst;
      repeat (400) @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      bus(4'h8, 32'h0, 1'b0);
      chk(q, 32'h0);
      $display("disabled monitor done");
      mode <= 3'h3;
      do_rst;
      bus(4'h4, 32'h0, 1'b0);
      chk(q, 32'h1);
      $display("timer skip done");
      give_verdict;
   end
endmodule
`default_nettype wire
